// File: inc/dao_pkg.sv
// Package: constants and types for the address map and termination block
package dao_pkg;
   localparam int ADDR_W = 32;
   localparam int LEN_W = 16;
   localparam int NCS = 8;
   localparam int COL_MAX_W = 12;
   localparam int ROW_MAX_W = 16;
   localparam int BANK_MAX_W = 3;
   localparam int CS_W = 3;
   // Field start = configured base plus these offsets
   localparam logic [5:0] ROW_POS_OFS = 6'h09;
   localparam logic [5:0] BANK_POS_OFS = 6'h13;
   localparam logic [5:0] CS_POS_OFS = 6'h13;
   // Burst of 8 beats: 2^3 beats per memory access
   localparam logic [5:0] BURST_SHIFT = 6'h03;

   typedef struct packed {
      logic registered_memory_module;
      logic [3:0] cas_latency;
      logic [2:0] odt_delay;
      logic [2:0] odt_hold;
      logic [7:0][7:0] odt_rd_matrix;
      logic [7:0][7:0] odt_wr_matrix;
      logic [7:0] odt_idle;
      logic [7:0] phy_rd_term_en;
      logic [7:0] wl_odt;
      logic [2:0] wl_rtt;
      logic [7:0][2:0] rtt_nom;
      logic [7:0][1:0] rtt_wr;
      logic [7:0][1:0] drv_imp;
      logic [4:0] column_field_base;
      logic [4:0] row_field_base;
      logic [4:0] bank_field_base;
      logic [4:0] chip_select_field_base;
      logic [1:0] port_count_exponent;
   } dao_cfg_t;

   localparam dao_cfg_t DAO_CFG_RST = '0;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [LEN_W-1:0] len;
   } dao_req_t;

   typedef struct packed {
      logic write;
      logic [CS_W-1:0] cs;
      logic [BANK_MAX_W-1:0] bank;
      logic [ROW_MAX_W-1:0] row;
      logic [COL_MAX_W-1:0] col;
   } dao_cmd_t;

   typedef struct packed {
      logic [2:0] rtt;
      logic [1:0] rtt_wr;
      logic [1:0] drv;
   } dao_mr_t;

   typedef enum logic [1:0] {
      SPL_IDLE = 2'h0,
      SPL_BURST = 2'h1
   } dao_spl_t;

   typedef enum logic [1:0] {
      ODT_IDLE = 2'h0,
      ODT_WAIT = 2'h1,
      ODT_ON = 2'h3
   } dao_odt_t;
endpackage

// File: logic/dao_addr_split.sv
// Address decoder: bus byte address to column, row, bank and chip select
`timescale 1ns/10ps
`default_nettype none
module dao_addr_split (
   input wire logic [dao_pkg::ADDR_W-1:0] addr_in,
   input wire dao_pkg::dao_cfg_t cfg_in,
   input wire logic [1:0] port_id_in,
   output dao_pkg::dao_cmd_t fld_out
);
   import dao_pkg::*;

   function automatic logic [15:0] mask_f(input logic [5:0] w, input logic [5:0] wmax);
      logic [5:0] lim;
      lim = (w > wmax) ? wmax : w;
      mask_f = 16'((17'h1 << lim) - 17'h1);
   endfunction

   logic [5:0] col_pos, row_pos, bank_pos, cs_pos;
   logic [ADDR_W-1:0] col_sh, row_sh, bank_sh, cs_sh;
   logic [15:0] col_m, row_m, bank_m, port_m;

   always_comb begin
      col_pos = {1'b0, cfg_in.column_field_base};
      row_pos = 6'({1'b0, cfg_in.row_field_base} + ROW_POS_OFS);
      bank_pos = 6'({1'b0, cfg_in.bank_field_base} + BANK_POS_OFS);
      cs_pos = 6'({1'b0, cfg_in.chip_select_field_base} + CS_POS_OFS);
      col_sh = addr_in >> col_pos;
      row_sh = addr_in >> row_pos;
      bank_sh = addr_in >> bank_pos;
      cs_sh = addr_in >> cs_pos;
      // Widths follow from neighbouring starts, capped at 12, 16 and 3 bits
      col_m = mask_f(6'(row_pos - col_pos), 6'h0c);
      row_m = mask_f(6'(bank_pos - row_pos), 6'h10);
      bank_m = mask_f(6'(cs_pos - bank_pos), 6'h03);
      port_m = mask_f({4'h0, cfg_in.port_count_exponent}, 6'h02);
      fld_out.write = 1'b0;
      fld_out.col = col_sh[COL_MAX_W-1:0] & col_m[COL_MAX_W-1:0];
      fld_out.row = row_sh[ROW_MAX_W-1:0] & row_m;
      // Port number fills the low bank bits in multi-port builds
      fld_out.bank = 3'((({13'h0, bank_sh[2:0]} & bank_m) << cfg_in.port_count_exponent)
                     | ({14'h0, port_id_in} & port_m));
      fld_out.cs = cs_sh[CS_W-1:0];
   end
endmodule
`default_nettype wire

// File: logic/dao_top.sv
// Top: burst splitting, address mapping, ODT control and configuration store
// Operation
// - Registered module bit adds one cycle to internal control latency.
// - Per chip select termination, write termination and impedance for mode register.
// - ODT enable matrix per chip select for reads and for writes.
// - Idle ODT pattern between accesses; all ODT off after reset.
// - ODT switch delay programmable, earliest one cycle after the command.
// - Per chip select PHY-side read termination enable.
// - Write leveling uses its own termination value and ODT pattern.
// - Configuration loaded from input signals at reset, or written later.
// - Every memory access is a burst of 8; bus accesses split.
// - Each port maps to its own fixed set of internal banks.
// - Lowest address bits select the byte lane, two to four bits.
// - Column field 9 to 12 bits, then row field 12 to 16 bits.
// - Bank field 0 to 3 bits, low bits implied by port.
// - Topmost field is 3-bit chip select.
`timescale 1ns/10ps
`default_nettype none
module dao_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire dao_pkg::dao_cfg_t cfg_init_in,
   input wire logic cfg_wr_in,
   input wire dao_pkg::dao_cfg_t cfg_wdata_in,
   output dao_pkg::dao_cfg_t cfg_out,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire dao_pkg::dao_req_t req_in,
   input wire logic [1:0] port_id_in,
   output logic cmd_valid_out,
   input wire logic cmd_ready_in,
   output dao_pkg::dao_cmd_t cmd_out,
   output logic cmd_last_out,
   input wire logic wl_active_in,
   output logic [7:0] odt_out,
   output logic phy_rd_term_out,
   input wire logic [2:0] mr_cs_sel_in,
   output dao_pkg::dao_mr_t mr_out,
   output logic [4:0] ctrl_latency_out
);
   import dao_pkg::*;

   // ------------------------------------------------------------
   // Configuration store
   // ------------------------------------------------------------
   dao_cfg_t cfg_r, cfg_nxt;
   logic loaded_r, loaded_nxt;

   always_comb begin
      cfg_nxt = cfg_r;
      loaded_nxt = 1'b1;
      // Strap values taken on the first edge after reset release
      if (!loaded_r) begin
         cfg_nxt = cfg_init_in;
      end else if (cfg_wr_in) begin
         cfg_nxt = cfg_wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_r <= DAO_CFG_RST;
         loaded_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         loaded_r <= loaded_nxt;
      end
   end

   assign cfg_out = cfg_r;

   // ------------------------------------------------------------
   // Latency and mode register values
   // ------------------------------------------------------------
   logic [4:0] lat_r, lat_nxt;
   dao_mr_t mr_r, mr_nxt;

   always_comb begin
      lat_nxt = {1'b0, cfg_r.cas_latency} + {4'h0, cfg_r.registered_memory_module};
      mr_nxt.rtt = wl_active_in ? cfg_r.wl_rtt : cfg_r.rtt_nom[mr_cs_sel_in];
      mr_nxt.rtt_wr = cfg_r.rtt_wr[mr_cs_sel_in];
      mr_nxt.drv = cfg_r.drv_imp[mr_cs_sel_in];
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lat_r <= 5'h00;
         mr_r <= '0;
      end else begin
         lat_r <= lat_nxt;
         mr_r <= mr_nxt;
      end
   end

   assign ctrl_latency_out = lat_r;
   assign mr_out = mr_r;

   // ------------------------------------------------------------
   // Burst splitter
   // ------------------------------------------------------------
   dao_spl_t spl_r, spl_nxt;
   logic [ADDR_W-1:0] cur_r, cur_nxt;
   logic [ADDR_W:0] end_r, end_nxt;
   logic wr_r, wr_nxt;
   logic [1:0] port_r, port_nxt;
   dao_cmd_t cmd_r, cmd_nxt;
   logic last_r, last_nxt;
   logic [ADDR_W-1:0] bmask, start_addr, next_addr, dec_addr;
   logic [ADDR_W:0] req_end, next_ext;
   logic [1:0] dec_port;
   logic cmd_fire;
   dao_cmd_t fld;

   assign cmd_fire = (spl_r == SPL_BURST) && cmd_ready_in;

   dao_addr_split u_split (
      .addr_in(dec_addr),
      .cfg_in(cfg_r),
      .port_id_in(dec_port),
      .fld_out(fld)
   );

   always_comb begin
      // One burst covers 8 beats of the data bus width
      bmask = 32'((33'h1 << (6'({1'b0, cfg_r.column_field_base}) + BURST_SHIFT)) - 33'h1);
      start_addr = req_in.addr & ~bmask;
      req_end = {1'b0, req_in.addr}
         + ((req_in.len == 16'h0000) ? 33'h0 : {17'h0, req_in.len} - 33'h1);
      next_ext = {1'b0, cur_r | bmask} + 33'h1;
      next_addr = next_ext[ADDR_W-1:0];
      spl_nxt = spl_r;
      cur_nxt = cur_r;
      end_nxt = end_r;
      wr_nxt = wr_r;
      port_nxt = port_r;
      cmd_nxt = cmd_r;
      last_nxt = last_r;
      dec_addr = next_addr;
      dec_port = port_r;
      case (spl_r)
         SPL_IDLE: begin
            dec_addr = start_addr;
            dec_port = port_id_in;
            if (req_valid_in && loaded_r) begin
               spl_nxt = SPL_BURST;
               cur_nxt = start_addr;
               end_nxt = req_end;
               wr_nxt = req_in.write;
               port_nxt = port_id_in;
               cmd_nxt = fld;
               cmd_nxt.write = req_in.write;
               last_nxt = ({1'b0, start_addr | bmask} >= req_end);
            end
         end
         SPL_BURST: begin
            if (cmd_ready_in) begin
               if (last_r) begin
                  spl_nxt = SPL_IDLE;
               end else begin
                  // Split continues at the next burst boundary
                  cur_nxt = next_addr;
                  cmd_nxt = fld;
                  cmd_nxt.write = wr_r;
                  last_nxt = ({1'b0, next_addr | bmask} >= end_r);
               end
            end
         end
         default: begin
            spl_nxt = SPL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         spl_r <= SPL_IDLE;
         cur_r <= 32'h0000_0000;
         end_r <= 33'h0_0000_0000;
         wr_r <= 1'b0;
         port_r <= 2'h0;
         cmd_r <= '0;
         last_r <= 1'b0;
      end else begin
         spl_r <= spl_nxt;
         cur_r <= cur_nxt;
         end_r <= end_nxt;
         wr_r <= wr_nxt;
         port_r <= port_nxt;
         cmd_r <= cmd_nxt;
         last_r <= last_nxt;
      end
   end

   // Requests wait until configuration is loaded
   assign req_ready_out = (spl_r == SPL_IDLE) && loaded_r;
   assign cmd_valid_out = (spl_r == SPL_BURST);
   assign cmd_out = cmd_r;
   assign cmd_last_out = last_r;

   // ------------------------------------------------------------
   // ODT sequencing
   // ------------------------------------------------------------
   dao_odt_t odt_st_r, odt_st_nxt;
   logic [3:0] odt_cnt_r, odt_cnt_nxt;
   logic [7:0] pat_r, pat_nxt;
   logic term_r, term_nxt;
   logic [7:0] odt_r, odt_nxt;
   logic rdt_r, rdt_nxt;
   logic [3:0] eff_delay;
   logic [7:0] idle_pat, cmd_pat;
   logic cmd_term;

   always_comb begin
      // Registered modules see commands one cycle late, so ODT follows
      eff_delay = {1'b0, cfg_r.odt_delay} + {3'h0, cfg_r.registered_memory_module};
      idle_pat = wl_active_in ? cfg_r.wl_odt : cfg_r.odt_idle;
      cmd_pat = cmd_r.write ? cfg_r.odt_wr_matrix[cmd_r.cs]
                            : cfg_r.odt_rd_matrix[cmd_r.cs];
      cmd_term = !cmd_r.write && cfg_r.phy_rd_term_en[cmd_r.cs];
      odt_st_nxt = odt_st_r;
      odt_cnt_nxt = odt_cnt_r;
      pat_nxt = pat_r;
      term_nxt = term_r;
      odt_nxt = idle_pat;
      rdt_nxt = 1'b0;
      case (odt_st_r)
         ODT_IDLE: begin
            odt_nxt = idle_pat;
         end
         ODT_WAIT: begin
            odt_nxt = idle_pat;
            if (odt_cnt_r == 4'h0) begin
               odt_st_nxt = ODT_ON;
               odt_cnt_nxt = {1'b0, cfg_r.odt_hold};
               odt_nxt = pat_r;
               rdt_nxt = term_r;
            end else begin
               odt_cnt_nxt = odt_cnt_r - 4'h1;
            end
         end
         ODT_ON: begin
            if (odt_cnt_r == 4'h0) begin
               odt_st_nxt = ODT_IDLE;
               odt_nxt = idle_pat;
            end else begin
               odt_cnt_nxt = odt_cnt_r - 4'h1;
               odt_nxt = pat_r;
               rdt_nxt = term_r;
            end
         end
         default: begin
            odt_st_nxt = ODT_IDLE;
         end
      endcase
      // A new command restarts the sequence; delay 0 switches next cycle
      if (cmd_fire) begin
         pat_nxt = cmd_pat;
         term_nxt = cmd_term;
         if (eff_delay == 4'h0) begin
            odt_st_nxt = ODT_ON;
            odt_cnt_nxt = {1'b0, cfg_r.odt_hold};
            odt_nxt = cmd_pat;
            rdt_nxt = cmd_term;
         end else begin
            odt_st_nxt = ODT_WAIT;
            odt_cnt_nxt = eff_delay - 4'h1;
         end
      end
      if (wl_active_in) begin
         odt_nxt = cfg_r.wl_odt;
         rdt_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         odt_st_r <= ODT_IDLE;
         odt_cnt_r <= 4'h0;
         pat_r <= 8'h00;
         term_r <= 1'b0;
         odt_r <= 8'h00;
         rdt_r <= 1'b0;
      end else begin
         odt_st_r <= odt_st_nxt;
         odt_cnt_r <= odt_cnt_nxt;
         pat_r <= pat_nxt;
         term_r <= term_nxt;
         odt_r <= odt_nxt;
         rdt_r <= rdt_nxt;
      end
   end

   assign odt_out = odt_r;
   assign phy_rd_term_out = rdt_r;
endmodule
`default_nettype wire

// File: sim/dao_chk_sva.sv
// Checker: port-level properties of the address map and termination block
`timescale 1ns/10ps
`default_nettype none
module dao_chk (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire dao_pkg::dao_cfg_t cfg_out,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire dao_pkg::dao_req_t req_in,
   input wire logic [1:0] port_id_in,
   input wire logic cmd_valid_out,
   input wire logic cmd_ready_in,
   input wire dao_pkg::dao_cmd_t cmd_out,
   input wire logic wl_active_in,
   input wire logic [7:0] odt_out,
   input wire logic phy_rd_term_out,
   input wire logic [2:0] mr_cs_sel_in,
   input wire dao_pkg::dao_mr_t mr_out,
   input wire logic [4:0] ctrl_latency_out
);
   import dao_pkg::*;
   logic hs, take, eff1, term;
   logic [7:0] pat, idle;
   logic [3:0] mrx;
   logic [4:0] lat, quiet_r, quiet_nxt;
   // ----
   // Helpers
   // ----
   assign hs = cmd_valid_out & cmd_ready_in;
   assign take = req_valid_in & req_ready_out;
   assign eff1 = ({1'b0, cfg_out.odt_delay} + {3'h0, cfg_out.registered_memory_module}) == 4'h1;
   assign pat = cmd_out.write ? cfg_out.odt_wr_matrix[cmd_out.cs]
                              : cfg_out.odt_rd_matrix[cmd_out.cs];
   assign term = !cmd_out.write & cfg_out.phy_rd_term_en[cmd_out.cs];
   assign idle = cfg_out.odt_idle;
   assign mrx = {cfg_out.rtt_wr[mr_cs_sel_in], cfg_out.drv_imp[mr_cs_sel_in]};
   assign lat = {1'b0, cfg_out.cas_latency} + {4'h0, cfg_out.registered_memory_module};
   // Saturates, so a long quiet spell never wraps back into the window
   always_comb begin
      quiet_nxt = hs ? 5'h00 : quiet_r + {4'h0, quiet_r != 5'h1f};
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         quiet_r <= 5'h00;
      end else begin
         quiet_r <= quiet_nxt;
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_lat; ctrl_latency_out == $past(lat); endproperty
   a_lat: assert property (p_lat) else $error("latency wrong");
   property p_mr; {mr_out.rtt_wr, mr_out.drv} == $past(mrx); endproperty
   a_mr: assert property (p_mr) else $error("mode values wrong");
   property p_rst; $rose(rst_n_in) |-> odt_out == 8'h00 && !cmd_valid_out; endproperty
   a_rst: assert property (p_rst) else $error("not quiet after reset");
   property p_idle;
      quiet_r > 5'h14 && !wl_active_in && !$past(wl_active_in) |->
         odt_out == $past(idle) && !phy_rd_term_out;
   endproperty
   a_idle: assert property (p_idle) else $error("idle pattern wrong");
   property p_take; take |=> cmd_valid_out && cmd_out.write == $past(req_in.write); endproperty
   a_take: assert property (p_take) else $error("request not issued");
   property p_hold;
      cmd_valid_out && !cmd_ready_in |=> cmd_valid_out && $stable(cmd_out);
   endproperty
   a_hold: assert property (p_hold) else $error("command dropped");
   property p_col; cmd_valid_out |-> cmd_out.col[2:0] == 3'h0; endproperty
   a_col: assert property (p_col) else $error("burst not aligned");
   property p_port;
      take && cfg_out.port_count_exponent == 2'h1 |=>
         {1'b0, cmd_out.bank[0]} == ($past(port_id_in) & 2'h1);
   endproperty
   a_port: assert property (p_port) else $error("port bank wrong");
   property p_odt;
      hs && eff1 && !wl_active_in ##1 !hs && !wl_active_in ##1 !wl_active_in |->
         odt_out == $past(pat, 2) && phy_rd_term_out == $past(term, 2);
   endproperty
   a_odt: assert property (p_odt) else $error("odt switch wrong");
   property p_wl;
      wl_active_in |=> odt_out == $past(cfg_out.wl_odt) && !phy_rd_term_out;
   endproperty
   a_wl: assert property (p_wl) else $error("leveling odt wrong");
   c_odt: cover property (hs && eff1);
   c_stall: cover property (cmd_valid_out && !cmd_ready_in);
   c_wl: cover property (wl_active_in);
endmodule
`default_nettype wire

// File: sim/dao_phy_model.sv
// Command consumer standing in for the PHY side
`timescale 1ns/10ps
`default_nettype none
module dao_phy_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic slow_in,
   input wire logic cmd_valid_in,
   input wire dao_pkg::dao_cmd_t cmd_in,
   input wire logic cmd_last_in,
   output logic cmd_ready_out
);
   import dao_pkg::*;
   dao_cmd_t got[0:15];
   logic got_last[0:15];
   int n_got;
   logic [1:0] cnt;
   // Slow mode takes one of three cycles, so the block must hold its command
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= 2'h0;
         cmd_ready_out <= 1'b0;
         n_got <= 0;
      end else begin
         cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
         cmd_ready_out <= !slow_in || cnt == 2'h1;
         if (cmd_valid_in && cmd_ready_out) begin
            got[n_got[3:0]] <= cmd_in;
            got_last[n_got[3:0]] <= cmd_last_in;
            n_got <= n_got + 1;
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/dao_top_tb.sv
// Self-checking bench for the address map and termination block
`timescale 1ns/10ps
`default_nettype none
module dao_top_tb;
   import dao_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic cfg_wr_in = 1'b0;
   logic req_valid_in = 1'b0;
   logic wl_active_in = 1'b0;
   logic slow = 1'b0;
   logic req_ready_out, cmd_valid_out, cmd_ready_in, cmd_last_out, phy_rd_term_out;
   logic [1:0] port_id_in = 2'h0;
   logic [2:0] mr_cs_sel_in = 3'h5;
   logic [4:0] ctrl_latency_out;
   logic [7:0] odt_out;
   dao_cfg_t cfg, cfg_wdata_in, cfg_out;
   dao_req_t req_in = '0;
   dao_cmd_t cmd_out;
   dao_mr_t mr_out;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   int seen = 0;
   int n_rd_odt = 0;
   dao_top u_dut (.clk_in, .rst_n_in, .cfg_init_in(cfg), .cfg_wr_in, .cfg_wdata_in, .cfg_out,
      .req_valid_in, .req_ready_out, .req_in, .port_id_in, .cmd_valid_out, .cmd_ready_in,
      .cmd_out, .cmd_last_out, .wl_active_in, .odt_out, .phy_rd_term_out, .mr_cs_sel_in,
      .mr_out, .ctrl_latency_out);
   dao_phy_model u_phy (.clk_in, .rst_n_in, .slow_in(slow), .cmd_valid_in(cmd_valid_out),
      .cmd_in(cmd_out), .cmd_last_in(cmd_last_out), .cmd_ready_out(cmd_ready_in));
   always #50 clk_in = ~clk_in;
   // Reads of chip select 5 show its read pattern with PHY termination
   always @(negedge clk_in) begin
      if (odt_out == 8'h24 && phy_rd_term_out) begin
         n_rd_odt <= n_rd_odt + 1;
      end
   end
   // ----
   // Tasks
   // ----
   task end_sim;
      if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [255:0] g, input logic [255:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic do_req(input logic w, input logic [31:0] a, input logic [15:0] l,
         input logic [1:0] p, input int nb);
      logic [31:0] b;
      dao_cmd_t e;
      @(posedge clk_in);
      req_valid_in <= 1'b1;
      req_in <= '{w, a, l};
      port_id_in <= p;
      @(negedge clk_in);
      while (req_ready_out !== 1'b1) @(negedge clk_in);
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      while (u_phy.n_got < seen + nb) @(negedge clk_in);
      for (int i = 0; i < nb; i++) begin
         b = (a & 32'hffff_ffc0) + 32'(i * 64);
         e = '{w, b[29:27], {b[26:25], p[0]}, {4'h0, b[24:13]}, {2'h0, b[12:3]}};
         chk(u_phy.got[seen + i], e);
         chk(u_phy.got_last[seen + i], i == nb - 1);
      end
      seen += nb;
   endtask
   // ----
   // Sequence
   // ----
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         end_sim();
      end
   end
   initial begin
      cfg = '0;
      cfg_wdata_in = '0;
      cfg.cas_latency = 4'h5;
      cfg.odt_delay = 3'h1;
      cfg.odt_hold = 3'h1;
      cfg.odt_wr_matrix[5] = 8'h21;
      cfg.odt_rd_matrix[5] = 8'h24;
      cfg.odt_idle = 8'h80;
      cfg.phy_rd_term_en = 8'h20;
      cfg.wl_odt = 8'h0f;
      cfg.wl_rtt = 3'h2;
      cfg.rtt_nom[5] = 3'h3;
      cfg.rtt_nom[2] = 3'h6;
      cfg.rtt_wr[5] = 2'h2;
      cfg.drv_imp[5] = 2'h1;
      cfg.column_field_base = 5'h03;
      cfg.row_field_base = 5'h04;
      cfg.bank_field_base = 5'h06;
      cfg.chip_select_field_base = 5'h08;
      cfg.port_count_exponent = 2'h1;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk(odt_out, 8'h00);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(negedge clk_in);
      chk(cfg_out, cfg);
      chk(ctrl_latency_out, 5'h05);
      chk(mr_out, {3'h3, 2'h2, 2'h1});
      // Second burst carries the column over into the next row
      do_req(1'b1, 32'h2d57_9fc5, 16'h0040, 2'h1, 2);
      @(posedge clk_in);
      slow <= 1'b1;
      do_req(1'b0, 32'h2a00_0007, 16'h0000, 2'h0, 1);
      do_req(1'b0, 32'h0000_0030, 16'h0090, 2'h3, 3);
      repeat (25) @(negedge clk_in);
      chk(odt_out, 8'h80);
      chk(phy_rd_term_out, 1'b0);
      chk(n_rd_odt, 32'h2);
      @(posedge clk_in);
      wl_active_in <= 1'b1;
      repeat (2) @(negedge clk_in);
      chk(odt_out, 8'h0f);
      chk(mr_out.rtt, 3'h2);
      @(posedge clk_in);
      wl_active_in <= 1'b0;
      cfg.cas_latency = 4'hf;
      cfg.registered_memory_module = 1'b1;
      cfg.odt_idle = 8'h21;
      @(posedge clk_in);
      cfg_wdata_in <= cfg;
      cfg_wr_in <= 1'b1;
      @(posedge clk_in);
      cfg_wr_in <= 1'b0;
      repeat (2) @(negedge clk_in);
      chk(cfg_out, cfg);
      chk(ctrl_latency_out, 5'h10);
      @(posedge clk_in);
      mr_cs_sel_in <= 3'h2;
      repeat (2) @(negedge clk_in);
      chk(mr_out, {3'h6, 2'h0, 2'h0});
      do_req(1'b1, 32'h2800_0000, 16'h0001, 2'h2, 1);
      repeat (25) @(negedge clk_in);
      chk(odt_out, 8'h21);
      end_sim();
   end
endmodule
bind dao_top dao_chk u_chk (.clk_in, .rst_n_in, .cfg_out, .req_valid_in, .req_ready_out,
   .req_in, .port_id_in, .cmd_valid_out, .cmd_ready_in, .cmd_out, .wl_active_in, .odt_out,
   .phy_rd_term_out, .mr_cs_sel_in, .mr_out, .ctrl_latency_out);
`default_nettype wire
